// ### src/fcl_defs.vh
// Purpose: shared constants of the field compensation and linearizer stage
// Assumes: 26-bit configuration words, one per word address
// Notes: numeric scales of gains and drift codes are fixed here
// Contract
// - polarity bit flips sensitivity sign
// - coarse and fine gain scale sample
// - hot and cold first-order gain drift
// - hot and cold second-order gain drift
// - delta temperature against 25 C selects set
// - add 18-bit quiescent offset field
// - add hot or cold drift times delta
// - up to sixteen straight table segments
// - interpolate linearly between table points
// - entries are 13-bit, signed in lin mode
// - seventeen equally spaced points in lin mode
// - select bit 0 lin, 1 bin mode
// - bin entries 0-7 levels, 8-15 locations
// - location is input/8 plus 4096
// - lin coefficient is delta output over four
// - bin level is output/8 plus 4096
// - lin reach 25 percent, 50 when scaled
// - gain times one plus drift polynomial
// - compensated result is 16-bit signed
// - table applied only when enable set
// - scaling bit doubles lin coefficients and bin levels, not bin locations
`ifndef FCL_DEFS_VH
`define FCL_DEFS_VH
// word addresses
`define FCL_A_SENS      5'h03
`define FCL_A_TC1       5'h04
`define FCL_A_TC2       5'h05
`define FCL_A_QO        5'h06
`define FCL_A_QOTC      5'h07
`define FCL_A_LIN0      5'h0a
`define FCL_A_LIN8      5'h12
`define FCL_NWORDS      14
// field positions
`define FCL_POL_BIT     15
`define FCL_SENSM_HI    14
`define FCL_SENSM_LO    12
`define FCL_SENS_HI     10
`define FCL_TC1_HOT_HI  10
`define FCL_TC1_CLD_HI  22
`define FCL_TC1_CLD_LO  12
`define FCL_TC2_HOT_HI  9
`define FCL_TC2_CLD_HI  21
`define FCL_TC2_CLD_LO  12
`define FCL_QO_HI       17
`define FCL_QOTC_HOT_HI 11
`define FCL_QOTC_CLD_HI 23
`define FCL_QOTC_CLD_LO 12
`define FCL_LINE_BIT    13
`define FCL_BINE_BIT    14
`define FCL_OINV_BIT    15
`define FCL_IINV_BIT    16
`define FCL_HYST_HI     24
`define FCL_HYST_LO     17
`define FCL_SCAL_BIT    25
// reset values
`define FCL_SENS_RST    26'h0000400
`define FCL_WORD_RST    26'h0000000
// arithmetic scales
`define FCL_TREF        10'h019
`define FCL_FINE_SH     10
`define FCL_GAIN_ONE    32'h00010000
`define FCL_GAIN_SH     16
`define FCL_TC_SCALE    64
`define FCL_TC2_DIV     1000
`define FCL_PCT_DIV     100
`define FCL_SEG_SH      12
`define FCL_LOC_OFS     13'h1000
`define FCL_ENT_W       13
`endif

// ### src/fcl_lin_interp.v
// Purpose: fixed-point mode table interpolation
// Assumes: seventeen 13-bit signed entries packed low first
// Notes: returns unsaturated sum, caller clamps
`timescale 1ns/100ps
`default_nettype none
`include "fcl_defs.vh"
module fcl_lin_interp (
  input  wire [15:0]  lin_in,
  input  wire [220:0] tab_flat,
  input  wire         scale_x2,
  output wire [19:0]  lin_sum
);
  // equal spacing: position 0..65535 split into 16 steps
  wire [15:0] pos = {~lin_in[15], lin_in[14:0]};
  wire [4:0]  s0  = {1'b0, pos[15:12]};
  wire [4:0]  s1  = s0 + 5'h01;
  wire [12:0] e0  = tab_flat[s0*`FCL_ENT_W +: `FCL_ENT_W];
  wire [12:0] e1  = tab_flat[s1*`FCL_ENT_W +: `FCL_ENT_W];
  // coefficient times four, doubled when scaled
  wire signed [16:0] k0 = scale_x2 ? {e0[12], e0, 3'h0} : {{2{e0[12]}}, e0, 2'h0};
  wire signed [16:0] k1 = scale_x2 ? {e1[12], e1, 3'h0} : {{2{e1[12]}}, e1, 2'h0};
  wire signed [31:0] prod = ($signed({k1[16], k1}) - $signed({k0[16], k0})) * $signed({1'b0, pos[11:0]});
  wire signed [19:0] dlt  = prod[31:12];
  assign lin_sum = $signed({{4{lin_in[15]}}, lin_in}) + $signed({{3{k0[16]}}, k0}) + dlt;
endmodule // fcl_lin_interp
`default_nettype wire

// ### src/fcl_bin_step.v
// Purpose: movable-point mode step selection with hysteresis
// Assumes: entries 0-7 levels, 8-15 locations
// Notes: bin 8 means below the first location
`timescale 1ns/100ps
`default_nettype none
`include "fcl_defs.vh"
module fcl_bin_step (
  input  wire [15:0]  bin_in,
  input  wire [207:0] tab_flat,
  input  wire [3:0]   cur_bin,
  input  wire [7:0]   hyst,
  input  wire         scale_x2,
  output reg  [3:0]   new_bin,
  output reg  [19:0]  bin_sum
);
  reg signed [19:0] thr;
  reg [12:0]        ent;
  integer           x;
  // highest location at or below the input
  always @*
  begin
    new_bin = 4'h8;
    thr     = 20'h0;
    ent     = 13'h0;
    for (x = 0; x < 8; x = x + 1)
    begin
      ent = tab_flat[(x + 8) * `FCL_ENT_W +: `FCL_ENT_W];
      thr = $signed({4'h0, ent, 3'h0}) - 20'sh08000;
      // hysteresis only lowers thresholds the output would fall past
      if (cur_bin != 4'h8 && x <= cur_bin)
        thr = thr - $signed({11'h0, hyst, 1'b0});
      if (x == 0 && ent == 13'h0)
        new_bin = 4'h0;
      else if ($signed({{4{bin_in[15]}}, bin_in}) >= thr)
        new_bin = x[3:0];
    end
    // level is (entry - 4096) * 8, doubled when scaled
    if (new_bin == 4'h8)
      bin_sum = 20'h0;
    else
    begin
      ent     = tab_flat[new_bin[2:0] * `FCL_ENT_W +: `FCL_ENT_W];
      bin_sum = ($signed({4'h0, ent, 3'h0}) - 20'sh08000) <<< scale_x2;
    end
  end
endmodule // fcl_bin_step
`default_nettype wire

// ### src/fcl_field_comp_linearizer.v
// Purpose: gain, drift, offset compensation then table linearization
// Assumes: samples and temperature arrive from logic on ref_clk
// Notes: five-cycle pipeline, configuration words written by address
`timescale 1ns/100ps
`default_nettype none
`include "fcl_defs.vh"
module fcl_field_comp_linearizer (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [4:0]  cfg_addr,
  input  wire [25:0] cfg_wdata,
  output wire [25:0] cfg_rdata,
  output wire        cfg_hit,
  input  wire        samp_valid,
  input  wire [15:0] samp_in,
  input  wire [8:0]  temp_in,
  output wire        comp_valid,
  output wire [15:0] comp_out,
  output wire        res_valid,
  output wire [15:0] res_out
);

  // clamp a wide signed value to 16 bits
  function [15:0] sat16;
    input signed [63:0] v;
    begin
      if (v > 64'sd32767)
        sat16 = 16'h7fff;
      else if (v < -64'sd32768)
        sat16 = 16'h8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  // negate a 16-bit value with saturation
  function [15:0] neg16;
    input [15:0] v;
    begin
      neg16 = sat16(-$signed({{48{v[15]}}, v}));
    end
  endfunction

  // clamp a 20-bit signed sum to 16 bits
  function [15:0] sat20;
    input [19:0] v;
    begin
      sat20 = sat16($signed({{44{v[19]}}, v}));
    end
  endfunction

  // address to storage index
  function [3:0] word_idx;
    input [4:0] a;
    begin
      if (a >= `FCL_A_LIN0)
        word_idx = a[3:0] - 4'h5;
      else
        word_idx = a[3:0] - 4'h3;
    end
  endfunction

  // address belongs to a stored word
  function word_ok;
    input [4:0] a;
    begin
      word_ok = (a >= `FCL_A_SENS && a <= `FCL_A_QOTC) || (a >= `FCL_A_LIN0 && a <= `FCL_A_LIN8);
    end
  endfunction

  // pick hot or cold coefficient
  function [11:0] pick;
    input        hot;
    input [11:0] h;
    input [11:0] c;
    begin
      pick = hot ? h : c;
    end
  endfunction

  // word storage and read-back registers
  reg  [25:0] word_reg [0:13];
  reg  [25:0] rdata_reg;
  reg         hit_reg;
  integer     i;

  // configuration word storage
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      word_reg[0] <= `FCL_SENS_RST;
      for (i = 1; i < `FCL_NWORDS; i = i + 1)
        word_reg[i] <= `FCL_WORD_RST;
    end
    else if (cfg_wr && word_ok(cfg_addr))
      word_reg[word_idx(cfg_addr)] <= cfg_wdata;
  end

  // registered read, unmapped words read zero
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= 26'h0;
      hit_reg   <= 1'b0;
    end
    else if (cfg_rd)
    begin
      rdata_reg <= word_ok(cfg_addr) ? word_reg[word_idx(cfg_addr)] : 26'h0;
      hit_reg   <= word_ok(cfg_addr);
    end
  end

  // read port
  assign cfg_rdata = rdata_reg;
  assign cfg_hit   = hit_reg;

  // named views of the words
  wire [25:0] w_sens = word_reg[0];
  wire [25:0] w_tc1  = word_reg[1];
  wire [25:0] w_tc2  = word_reg[2];
  wire [25:0] w_qo   = word_reg[3];
  wire [25:0] w_qotc = word_reg[4];
  wire [25:0] w_ctl  = word_reg[13];

  // configuration fields
  wire        pol_inv  = w_sens[`FCL_POL_BIT];
  wire [2:0]  coarse   = w_sens[`FCL_SENSM_HI:`FCL_SENSM_LO];
  wire [10:0] fine     = w_sens[`FCL_SENS_HI:0];
  wire        lin_en   = w_ctl[`FCL_LINE_BIT];
  wire        bin_mode = w_ctl[`FCL_BINE_BIT];
  wire        out_inv  = w_ctl[`FCL_OINV_BIT];
  wire        in_inv   = w_ctl[`FCL_IINV_BIT];
  wire [7:0]  hyst     = w_ctl[`FCL_HYST_HI:`FCL_HYST_LO];
  wire        scale_x2 = w_ctl[`FCL_SCAL_BIT];

  // table words flattened, two 13-bit entries per word, one entry in word 0x12 bits 12:0
  wire [220:0] tab_flat;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_tab
      assign tab_flat[g*26 +: 26] = word_reg[5 + g];
    end
  endgenerate
  assign tab_flat[220:208] = w_ctl[12:0];

  // stage 1: temperature delta and region selection
  reg               v1_reg;
  reg  signed [15:0] x1_reg;
  reg  signed [9:0]  dt1_reg;
  reg  signed [11:0] tc1_reg;
  reg  signed [11:0] tc2_reg;
  reg  signed [11:0] qotc_reg;
  // delta against the 25 C reference
  wire signed [9:0] dt_next = $signed({temp_in[8], temp_in}) - $signed(`FCL_TREF);
  // exactly zero delta counts as hot
  wire              hot = ~dt_next[9];

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      v1_reg   <= 1'b0;
      x1_reg   <= 16'h0;
      dt1_reg  <= 10'h0;
      tc1_reg  <= 12'h0;
      tc2_reg  <= 12'h0;
      qotc_reg <= 12'h0;
    end
    else
    begin
      v1_reg   <= samp_valid;
      x1_reg   <= samp_in;
      dt1_reg  <= dt_next;
      tc1_reg  <= pick(hot, {1'b0, w_tc1[`FCL_TC1_HOT_HI:0]},
                       {1'b0, w_tc1[`FCL_TC1_CLD_HI:`FCL_TC1_CLD_LO]}) ;
      tc2_reg  <= pick(hot, {2'h0, w_tc2[`FCL_TC2_HOT_HI:0]},
                       {2'h0, w_tc2[`FCL_TC2_CLD_HI:`FCL_TC2_CLD_LO]}) ;
      qotc_reg <= pick(hot, w_qotc[`FCL_QOTC_HOT_HI:0],
                       w_qotc[`FCL_QOTC_CLD_HI:`FCL_QOTC_CLD_LO]);
    end
  end

  // stage 2: gain factor, scaled sample and drift product
  reg                v2_reg;
  reg  signed [31:0] gain_reg;
  reg  signed [39:0] xs_reg;
  reg  signed [21:0] drift_reg;
  // inner term tc2 * dT / 1000 + tc1
  wire signed [31:0] inner = ($signed({{20{tc2_reg[11]}}, tc2_reg}) * dt1_reg) / `FCL_TC2_DIV
                             + $signed({{20{tc1_reg[11]}}, tc1_reg});
  // polynomial scaled to the Q16 gain
  wire signed [47:0] poly  = ($signed({{16{inner[31]}}, inner}) * dt1_reg * `FCL_TC_SCALE) / `FCL_PCT_DIV;
  // coarse gain as binary shift, fine gain over 1024
  wire signed [39:0] coarse_x = $signed({{24{x1_reg[15]}}, x1_reg}) <<< coarse;
  wire signed [51:0] fine_x   = coarse_x * $signed({1'b0, fine});
  wire signed [39:0] scaled   = fine_x[49:10];

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      v2_reg    <= 1'b0;
      gain_reg  <= 32'h0;
      xs_reg    <= 40'h0;
      drift_reg <= 22'h0;
    end
    else
    begin
      v2_reg    <= v1_reg;
      gain_reg  <= `FCL_GAIN_ONE + poly[31:0];
      xs_reg    <= pol_inv ? -scaled : scaled;
      drift_reg <= $signed({{10{qotc_reg[11]}}, qotc_reg}) * dt1_reg;
    end
  end

  // stage 3: apply temperature factor
  reg                v3_reg;
  reg  signed [15:0] y1_reg;
  reg  signed [21:0] drift3_reg;
  // full-width gain product
  wire signed [71:0] gprod = $signed({{32{xs_reg[39]}}, xs_reg}) * gain_reg;
  // back to unity scale, sign kept
  wire signed [63:0] gsh   = $signed({{8{gprod[71]}}, gprod[71:`FCL_GAIN_SH]});

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      v3_reg     <= 1'b0;
      y1_reg     <= 16'h0;
      drift3_reg <= 22'h0;
    end
    else
    begin
      v3_reg     <= v2_reg;
      y1_reg     <= sat16(gsh);
      drift3_reg <= drift_reg;
    end
  end

  // stage 4: quiescent offset and its drift
  reg                v4_reg;
  reg  signed [15:0] y2_reg;
  wire signed [17:0] qo = w_qo[`FCL_QO_HI:0];
  wire signed [23:0] y2_sum = $signed({{8{y1_reg[15]}}, y1_reg}) + $signed({{6{qo[17]}}, qo})
                              + $signed({{2{drift3_reg[21]}}, drift3_reg});

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      v4_reg <= 1'b0;
      y2_reg <= 16'h0;
    end
    else
    begin
      v4_reg <= v3_reg;
      if (v3_reg)
        y2_reg <= sat16($signed({{40{y2_sum[23]}}, y2_sum}));
    end
  end

  // compensation outputs
  assign comp_valid = v4_reg;
  assign comp_out   = y2_reg;

  // stage 5: linearization
  wire [15:0] lin_in = in_inv ? neg16(y2_reg) : y2_reg;
  wire [19:0] lin_sum;
  wire [19:0] bin_sum;
  wire [3:0]  new_bin;
  reg  [3:0]  bin_reg;

  // fixed-point interpolation
  fcl_lin_interp u_lin (
    .lin_in   (lin_in),
    .tab_flat (tab_flat),
    .scale_x2 (scale_x2),
    .lin_sum  (lin_sum)
  );

  // movable-point step with hysteresis
  fcl_bin_step u_bin (
    .bin_in   (lin_in),
    .tab_flat (tab_flat[207:0]),
    .cur_bin  (bin_reg),
    .hyst     (hyst),
    .scale_x2 (scale_x2),
    .new_bin  (new_bin),
    .bin_sum  (bin_sum)
  );

  // mode select, bit 1 is movable-point
  wire [15:0] table_out = bin_mode ? sat20(bin_sum) : sat20(lin_sum);
  // optional output inversion
  wire [15:0] inv_out   = out_inv ? neg16(table_out) : table_out;

  // output stage registers
  reg         v5_reg;
  reg  [15:0] res_reg;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      v5_reg  <= 1'b0;
      res_reg <= 16'h0;
      bin_reg <= 4'h8;
    end
    else
    begin
      v5_reg <= v4_reg;
      if (v4_reg)
      begin
        res_reg <= lin_en ? inv_out : y2_reg;
        // hysteresis state follows accepted samples in bin mode
        if (lin_en && bin_mode)
          bin_reg <= new_bin;
      end
    end
  end

  // linearizer outputs
  assign res_valid = v5_reg;
  assign res_out   = res_reg;

endmodule // fcl_field_comp_linearizer
`default_nettype wire

// ### tb/fcl_lin_sva.sv
// Purpose: port checks of the compensation and linearizer stage
// Assumes: config words stay put while samples are in flight
// Notes: table enable bit is shadowed from word 0x12 writes
`timescale 1ns/100ps
`default_nettype none
module fcl_lin_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [4:0]  cfg_addr,
  input wire logic [25:0] cfg_wdata,
  input wire logic [25:0] cfg_rdata,
  input wire logic        cfg_hit,
  input wire logic        samp_valid,
  input wire logic        comp_valid,
  input wire logic [15:0] comp_out,
  input wire logic        res_valid,
  input wire logic [15:0] res_out
);
  logic lin_en_reg;
  logic mapped;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // shadow of the table enable bit
  always @(posedge ref_clk or posedge rst)
    if (rst)
      lin_en_reg <= 1'b0;
    else if (cfg_wr && cfg_addr == 5'h12)
      lin_en_reg <= cfg_wdata[13];
  // mapped word decode
  assign mapped = (cfg_addr >= 5'h03 && cfg_addr <= 5'h07) || (cfg_addr >= 5'h0a && cfg_addr <= 5'h12);
  AST_COMP_LAT: assert property (samp_valid |-> ##4 comp_valid)
    else $error("no result four cycles after sample");
  AST_COMP_CAUSE: assert property (comp_valid |-> $past(samp_valid, 4))
    else $error("result without sample");
  AST_RES_LAT: assert property (comp_valid |=> res_valid)
    else $error("no table output after result");
  AST_RES_CAUSE: assert property (res_valid |-> $past(comp_valid))
    else $error("table output without result");
  AST_COMP_HOLD: assert property (!comp_valid |-> $stable(comp_out))
    else $error("result moved without pulse");
  AST_RES_HOLD: assert property (!res_valid |-> $stable(res_out))
    else $error("table output moved without pulse");
  AST_TABLE_OFF: assert property (res_valid && !lin_en_reg |-> res_out == $past(comp_out))
    else $error("disabled table changed value");
  AST_RD_MISS: assert property (cfg_rd && !mapped |=> !cfg_hit && cfg_rdata == 26'h0000000)
    else $error("unmapped read answered");
  AST_RD_HIT: assert property (cfg_rd && mapped |=> cfg_hit)
    else $error("mapped read missed");
  AST_RD_HOLD: assert property (!$past(cfg_rd) |-> $stable(cfg_rdata))
    else $error("read data moved without read");
  COV_BACK: cover property (comp_valid ##1 comp_valid);
  COV_TABLE: cover property (res_valid && lin_en_reg);
  COV_MISS: cover property (cfg_rd && !mapped);
endmodule // fcl_lin_sva
bind fcl_field_comp_linearizer fcl_lin_sva fcl_lin_sva_inst (.ref_clk(ref_clk), .rst(rst), .cfg_wr(cfg_wr),
  .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
  .samp_valid(samp_valid), .comp_valid(comp_valid), .comp_out(comp_out), .res_valid(res_valid), .res_out(res_out));
`default_nettype wire

// ### tb/fcl_filter_model.sv
// Purpose: upstream filter feeding samples and temperature
// Assumes: called 1 ns after a rising edge
// Notes: lines carry inverted junk between samples
`timescale 1ns/100ps
`default_nettype none
module fcl_filter_model (
  input  wire logic        ref_clk,
  output var  logic        samp_valid,
  output var  logic [15:0] samp_in,
  output var  logic [8:0]  temp_in
);
  // idle lines at start
  initial
  begin
    samp_valid = 1'b0;
    samp_in    = 16'h0000;
    temp_in    = 9'h019;
  end
  task automatic send(input logic [15:0] v, input logic [8:0] t, input logic more);
  begin
    samp_valid = 1'b1;
    samp_in    = v;
    temp_in    = t;
    @(posedge ref_clk);
    #1;
    if (!more)
    begin
      samp_valid = 1'b0;
      samp_in    = ~v;
      temp_in    = ~t;
    end
  end
  endtask
endmodule // fcl_filter_model
`default_nettype wire

// ### tb/fcl_field_comp_linearizer_test.sv
// Purpose: directed bench for the compensation and linearizer stage
// Assumes: fixed latencies of four and five cycles
// Notes: stimulus lands 1 ns after each rising edge
`timescale 1ns/100ps
`default_nettype none
module fcl_field_comp_linearizer_test;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_wr = 1'b0;
  logic        cfg_rd = 1'b0;
  logic [4:0]  cfg_addr = 5'h00;
  logic [25:0] cfg_wdata = 26'h0000000;
  logic [25:0] cfg_rdata;
  logic        cfg_hit;
  logic        samp_valid;
  logic [15:0] samp_in;
  logic [8:0]  temp_in;
  logic        comp_valid;
  logic [15:0] comp_out;
  logic        res_valid;
  logic [15:0] res_out;
  int          fails = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  fcl_field_comp_linearizer fcl_field_comp_linearizer_inst (.ref_clk(ref_clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
    .samp_valid(samp_valid), .samp_in(samp_in), .temp_in(temp_in), .comp_valid(comp_valid),
    .comp_out(comp_out), .res_valid(res_valid), .res_out(res_out));
  fcl_filter_model fcl_filter_model_inst (.ref_clk(ref_clk), .samp_valid(samp_valid), .samp_in(samp_in),
    .temp_in(temp_in));
  // clock and hang guard
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      close_out();
    end
  end
  // verdict and end of run
  task automatic close_out;
  begin
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // compares for words and samples
  task automatic cmp_reg(input logic [25:0] got, input logic [25:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task automatic cmp_smp(input logic [15:0] got, input logic [15:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  // config word access
  task automatic wr(input logic [4:0] a, input logic [25:0] d);
  begin
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge ref_clk);
    #1;
    cfg_wr = 1'b0;
    @(posedge ref_clk);
    #1;
  end
  endtask
  task automatic rd(input logic [4:0] a, input logic [25:0] exp, input logic hit);
  begin
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge ref_clk);
    #1;
    cfg_rd = 1'b0;
    cmp_reg(cfg_rdata, exp);
    cmp_reg({25'h0, cfg_hit}, {25'h0, hit});
    @(posedge ref_clk);
    #1;
  end
  endtask
  // one sample, result and table output
  task automatic smp(input logic [15:0] v, input logic [8:0] t, input logic [15:0] ec, input logic [15:0] er);
  begin
    fcl_filter_model_inst.send(v, t, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_smp({15'h0, comp_valid}, 16'h0001);
    cmp_smp(comp_out, ec);
    @(posedge ref_clk);
    #1;
    cmp_smp({15'h0, res_valid}, 16'h0001);
    cmp_smp(res_out, er);
  end
  endtask
  // reset values, read-back, unmapped read
  task automatic s_regs;
  begin
    rd(5'h03, 26'h0000400, 1'b1);
    rd(5'h06, 26'h0000000, 1'b1);
    rd(5'h08, 26'h0000000, 1'b0);
    wr(5'h0a, 26'h3ffffff);
    rd(5'h0a, 26'h3ffffff, 1'b1);
    wr(5'h0a, 26'h0000000);
  end
  endtask
  // back-to-back pass-through
  task automatic s_pass;
  begin
    fcl_filter_model_inst.send(16'h04d2, 9'h019, 1'b1);
    fcl_filter_model_inst.send(16'hfb2e, 9'h019, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    cmp_smp(comp_out, 16'h04d2);
    @(posedge ref_clk);
    #1;
    cmp_smp(comp_out, 16'hfb2e);
    cmp_smp(res_out, 16'h04d2);
    @(posedge ref_clk);
    #1;
    cmp_smp(res_out, 16'hfb2e);
  end
  endtask
  // polarity, coarse and fine gain
  task automatic s_gain;
  begin
    wr(5'h03, 26'h0008400);
    smp(16'h03e8, 9'h019, 16'hfc18, 16'hfc18);
    wr(5'h03, 26'h0001400);
    smp(16'h03e8, 9'h019, 16'h07d0, 16'h07d0);
    wr(5'h03, 26'h0001200);
    smp(16'h03e8, 9'h019, 16'h03e8, 16'h03e8);
    wr(5'h03, 26'h0000400);
  end
  endtask
  // hot and cold gain drift
  task automatic s_temp;
  begin
    wr(5'h04, 26'h0200400);
    smp(16'h03e8, 9'h07d, 16'h07d0, 16'h07d0);
    smp(16'h03e8, 9'h1b5, 16'h01f4, 16'h01f4);
    smp(16'h03e8, 9'h019, 16'h03e8, 16'h03e8);
    wr(5'h04, 26'h0000000);
    wr(5'h05, 26'h00003e8);
    smp(16'h0a00, 9'h07d, 16'h0afa, 16'h0afa);
    wr(5'h05, 26'h0000000);
  end
  endtask
  // quiescent offset and its drift
  task automatic s_offset;
  begin
    wr(5'h06, 26'h0000064);
    wr(5'h07, 26'h0005003);
    smp(16'h03e8, 9'h023, 16'h046a, 16'h046a);
    smp(16'h03e8, 9'h00f, 16'h041a, 16'h041a);
    smp(16'h03e8, 9'h019, 16'h044c, 16'h044c);
    wr(5'h06, 26'h0000000);
    wr(5'h07, 26'h0000000);
  end
  endtask
  // fixed-point table, scaling, disable
  task automatic s_lin;
  begin
    wr(5'h0e, 26'h0190064);
    wr(5'h12, 26'h0002000);
    smp(16'h0000, 9'h019, 16'h0000, 16'h0190);
    smp(16'h0800, 9'h019, 16'h0800, 16'h0a58);
    wr(5'h12, 26'h2002000);
    smp(16'h0000, 9'h019, 16'h0000, 16'h0320);
    wr(5'h0e, 26'h0001f9c);
    smp(16'h0000, 9'h019, 16'h0000, 16'hfce0);
    wr(5'h12, 26'h201a000);
    smp(16'h0800, 9'h019, 16'h0800, 16'h0990);
    wr(5'h12, 26'h0000000);
    smp(16'h0000, 9'h019, 16'h0000, 16'h0000);
  end
  endtask
  // movable-point table steps
  task automatic s_bin;
  begin
    for (int i = 0; i < 4; i++)
    begin
      wr(5'h0a + 5'(i), {13'(4096 + 20 * i + 20), 13'(4096 + 20 * i + 10)});
      wr(5'h0e + 5'(i), {13'(4096 + 250 * i + 250), 13'(4096 + 250 * i + 125)});
    end
    wr(5'h12, 26'h0006000);
    smp(16'h01f4, 9'h019, 16'h01f4, 16'h0000);
    smp(16'h05dc, 9'h019, 16'h05dc, 16'h0050);
    smp(16'h2134, 9'h019, 16'h2134, 16'h0280);
    wr(5'h12, 26'h0c86000);
    smp(16'h1edc, 9'h019, 16'h1edc, 16'h0280);
    smp(16'h1e14, 9'h019, 16'h1e14, 16'h0230);
  end
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    s_regs();
    s_pass();
    s_gain();
    s_temp();
    s_offset();
    s_lin();
    s_bin();
    close_out();
  end
endmodule // fcl_field_comp_linearizer_test
`default_nettype wire
